/* dv/sipo_ctrl_model.sv */
// controller model: drives serial data, shift/storage clocks, clear and enable
// assumes the bench calls its tasks one at a time; pins change on falling system edges, except in shift_bit, which runs on delays
`timescale 1ns/100ps
module sipo_ctrl_model (
    // pacing clock
    input  wire logic i_mclk,
    // link pins
    output logic      o_shift_clock,
    output logic      o_serial_in,
    // controller pins
    output logic      o_shift_clear_n,
    output logic      o_storage_clock,
    output logic      o_output_enable_n
);
    ////////////////////////////////////////////////////////////////////////////
    // idle levels: link clock parked low outside frames
    initial begin
        o_shift_clock     = 1'b0;
        o_serial_in       = 1'b0;
        o_shift_clear_n   = 1'b1;
        o_storage_clock   = 1'b0;
        o_output_enable_n = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one 64 ns link period; tied mode slows it so the storage pulse is seen
    task automatic shift_bit(input logic b, input bit tied);
        int half;
        half = tied ? 200 : 32;
        o_serial_in = b;
        #(half);
        o_shift_clock   = 1'b1;
        o_storage_clock = tied;
        #(half / 2);
        o_serial_in     = ~b;            // past the hold time: no stale level left behind
        #(half - half / 2);
        o_shift_clock   = 1'b0;
        o_storage_clock = 1'b0;
    endtask : shift_bit

    // storage pulse, three system periods high and three low
    task automatic store_pulse;
        @(negedge i_mclk);
        o_storage_clock = 1'b1;
        repeat (3) @(negedge i_mclk);
        o_storage_clock = 1'b0;
        repeat (3) @(negedge i_mclk);
    endtask : store_pulse

    // level pins, changed on a falling system edge
    task automatic set_pins(input logic clr_n, input logic oe_n);
        @(negedge i_mclk);
        o_shift_clear_n   = clr_n;
        o_output_enable_n = oe_n;
    endtask : set_pins
endmodule : sipo_ctrl_model

/* dv/tb_top.sv */
// self-checking bench: integer model of shift and storage registers
// assumes the controller model above sits on every latch input but the system clock and reset
`timescale 1ns/100ps
module tb_top;
    logic                    i_mclk;             // system clock
    logic                    i_rstn;             // system reset
    logic                    i_shift_clock;      // link clock
    logic                    i_serial_in;        // serial data
    logic                    i_shift_clear_n;    // stage clear
    logic                    i_storage_clock;    // storage clock
    logic                    i_output_enable_n;  // output enable
    logic [sipo_pkg::LAST:0] o_parallel_out;     // stored word
    logic [sipo_pkg::LAST:0] o_parallel_oe;      // drive enables
    logic                    o_cascade_out;      // last stage
    int                      failures;           // mismatches
    int                      n_compared;         // comparisons
    int                      m_shift;            // model stages
    int                      m_store;            // model storage
    int                      m_line[$];          // bits still inside the stages

    ////////////////////////////////////////////////////////////////////////////
    // clock, 40 ns period
    initial begin
        i_mclk = 1'b0;
        forever #20 i_mclk = ~i_mclk;
    end

    sipo_ctrl_model ctl (
        .i_mclk            (i_mclk),
        .o_shift_clock     (i_shift_clock),
        .o_serial_in       (i_serial_in),
        .o_shift_clear_n   (i_shift_clear_n),
        .o_storage_clock   (i_storage_clock),
        .o_output_enable_n (i_output_enable_n)
    );

    serial_in_parallel_out_latch DUT (
        .i_mclk            (i_mclk),
        .i_rstn            (i_rstn),
        .i_shift_clock     (i_shift_clock),
        .i_serial_in       (i_serial_in),
        .i_shift_clear_n   (i_shift_clear_n),
        .i_storage_clock   (i_storage_clock),
        .i_output_enable_n (i_output_enable_n),
        .o_parallel_out    (o_parallel_out),
        .o_parallel_oe     (o_parallel_oe),
        .o_cascade_out     (o_cascade_out)
    );

    ////////////////////////////////////////////////////////////////////////////
    // one comparison, reported on mismatch
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // shift n bits of v, msb first, checking the cascade after every edge
    task automatic send(input int v, input int n, input bit tied);
        for (int i = n - 1; i >= 0; i--) begin
            ctl.shift_bit(v[i], tied);
            if (tied) m_store = m_shift;  // storage sees the pre-edge stages
            m_shift = ((m_shift << 1) | v[i]) & 32'hff;
            m_line.push_back(v[i]);
            if (m_line.size() == sipo_pkg::WIDTH) begin
                check("chained", 8'(m_line.pop_front()), {7'h0, o_cascade_out});
            end
            check("cascade", 8'(m_shift >> 7), {7'h0, o_cascade_out});
            if (tied) check("tied store", 8'(m_store), o_parallel_out);
        end
    endtask : send

    // let the stages cross, pulse storage, compare the stored word
    task automatic store_and_check;
        m_store = m_shift;
        repeat (6) @(negedge i_mclk);
        ctl.store_pulse();
        check("stored", 8'(m_store), o_parallel_out);
    endtask : store_and_check

    // verdict, the only exit
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish

    ////////////////////////////////////////////////////////////////////////////
    // hang guard
    initial begin
        #3000000;
        failures++;
        $display("BAD watchdog expected finish seen hang");
        tally_and_finish();
    end

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        failures   = 0;
        n_compared = 0;
        m_shift    = 0;
        m_store    = 0;
        i_rstn     = 1'b0;
        void'($urandom(35));
        repeat (4) @(negedge i_mclk);
        i_rstn = 1'b1;
        repeat (4) @(negedge i_mclk);
        check("reset out", 8'h00, o_parallel_out);
        // random words, one of them sixteen bits long to show chaining
        for (int k = 0; k < 4; k++) begin
            send($urandom_range(16'hffff, 0), (k == 2) ? 16 : 8, 1'b0);
            store_and_check();
        end
        $display("test shift_store done");
        // both enable levels; the cascade keeps driving while floated
        for (int e = 1; e >= 0; e--) begin
            ctl.set_pins(1'b1, 1'(e));
            repeat (4) @(negedge i_mclk);
            check("enable", e ? 8'h00 : 8'hff, o_parallel_oe);
            check("cascade drive", 8'(m_shift >> 7), {7'h0, o_cascade_out});
        end
        check("enabled out", 8'(m_store), o_parallel_out);
        $display("test enable done");
        // clear: instant zero, overrides a shift, storage untouched
        send(8'hff, 8, 1'b0);
        ctl.set_pins(1'b0, 1'b0);
        #1;
        check("clear cascade", 8'h00, {7'h0, o_cascade_out});
        ctl.shift_bit(1'b1, 1'b0);
        check("clear shift", 8'h00, {7'h0, o_cascade_out});
        repeat (5) @(negedge i_mclk);
        check("clear store", 8'(m_store), o_parallel_out);
        ctl.store_pulse();
        m_store = 0;
        check("clear copy", 8'(m_store), o_parallel_out);
        ctl.set_pins(1'b1, 1'b0);
        m_shift = 0;
        m_line.delete();
        store_and_check();
        $display("test clear done");
        // tied clocks, storage one pulse behind
        send($urandom_range(255, 0), 8, 1'b1);
        $display("test tied done");
        tally_and_finish();
    end
endmodule : tb_top

/* hw/serial_in_parallel_out_latch.sv */
// eight-stage serial shift register with a storage register and
// tri-state parallel outputs, plus a cascade output
// assumes: shift clock, clear, storage clock and output enable come
// from an outside controller; i_mclk is a free-running system clock
`timescale 1ns/100ps
module serial_in_parallel_out_latch (
    // system clock and reset
    input  wire logic                 i_mclk,
    input  wire logic                 i_rstn,
    // link clock and serial data
    input  wire logic                 i_shift_clock,
    input  wire logic                 i_serial_in,
    // controller pins, asynchronous to i_mclk
    input  wire logic                 i_shift_clear_n,
    input  wire logic                 i_storage_clock,
    input  wire logic                 i_output_enable_n,
    // parallel outputs, value and enable per pin
    output logic [sipo_pkg::LAST:0]   o_parallel_out,
    output logic [sipo_pkg::LAST:0]   o_parallel_oe,
    // cascade output
    output logic                      o_cascade_out
);

    ////////////////////////////////////////////////////////////////
    // gray helpers for the crossing pointers

    // binary to gray
    function automatic sipo_pkg::ptr_t to_gray(input sipo_pkg::ptr_t b);
        return b ^ (b >> 1);
    endfunction : to_gray

    // gray to binary, msb down
    function automatic sipo_pkg::ptr_t to_bin(input sipo_pkg::ptr_t g);
        sipo_pkg::ptr_t b;
        b = g;
        for (int i = sipo_pkg::PTR_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction : to_bin

    ////////////////////////////////////////////////////////////////
    // link domain: the shift register itself

    // shift stages; cleared by the clear pin with no clock
    typedef struct packed {
        sipo_pkg::word_t shreg; // stage 0 in bit 0
    } link_sh_t;

    // crossing fifo, written on each shift edge
    typedef struct packed {
        sipo_pkg::word_t [sipo_pkg::DEPTH-1:0] mem;  // snapshots
        sipo_pkg::ptr_t                        wbin; // write pointer
        sipo_pkg::ptr_t                        wgray; // its gray copy
    } link_ptr_t;

    link_sh_t  sh_q;      // shift state
    link_sh_t  sh_d;      // its next value
    link_ptr_t lp_q;      // fifo write state
    link_ptr_t lp_d;      // its next value
    logic      link_rst_n; // clear or system reset

    // the clear pin acts as an asynchronous reset of the stages only
    assign link_rst_n = i_rstn && i_shift_clear_n;

    // next shift state: serial bit enters stage 0
    always_comb begin
        sh_d       = sh_q;
        sh_d.shreg = {sh_q.shreg[sipo_pkg::LAST-1:0], i_serial_in};
    end

    // stages move on the rising edge only; falling edge is ignored
    always_ff @(posedge i_shift_clock or negedge link_rst_n) begin
        if (!link_rst_n) begin
            sh_q.shreg <= sipo_pkg::ZERO_WORD;
        end else begin
            sh_q <= sh_d;
        end
    end

    // next fifo state: store the post-shift word, then advance
    always_comb begin
        lp_d = lp_q;
        // a shift edge under clear leaves the stages at zero, so log zero;
        // relies on the clear's setup time ahead of the shift edge
        lp_d.mem[lp_q.wbin[sipo_pkg::IDX_W-1:0]] = link_rst_n ? sh_d.shreg : sipo_pkg::ZERO_WORD;
        lp_d.wbin  = lp_q.wbin + sipo_pkg::PTR_ONE;
        lp_d.wgray = to_gray(lp_q.wbin + sipo_pkg::PTR_ONE);
    end

    // pointers survive a clear so the reader stays in step
    // no full check: the link clock cannot be stalled, and the
    // reader drains faster than the 64 ns shift rate can fill
    always_ff @(posedge i_shift_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            lp_q <= '0;
        end else begin
            lp_q <= lp_d;
        end
    end

    // cascade taps stage eight straight, not through storage
    assign o_cascade_out = sh_q.shreg[sipo_pkg::LAST];

    ////////////////////////////////////////////////////////////////
    // system domain: synchronisers, mirror and storage register

    // all system-domain state
    typedef struct packed {
        logic            clr_s1;  // clear, first flop
        logic            clr_s2;  // clear, second flop
        logic            stc_s1;  // storage clock, first flop
        logic            stc_s2;  // storage clock, second flop
        logic            stc_s3;  // previous of stc_s2
        logic            oen_s1;  // output enable, first flop
        logic            oen_s2;  // output enable, second flop
        sipo_pkg::ptr_t  wg_s1;   // write gray, first flop
        sipo_pkg::ptr_t  wg_s2;   // write gray, second flop
        sipo_pkg::ptr_t  rbin;    // read pointer
        sipo_pkg::word_t mirror;  // system copy of the stages
        sipo_pkg::word_t store;   // storage register
        logic            drive;   // parallel pins driven
    } sys_st_t;

    // inactive level of the enable pin: pins start and stay floating
    // until the synchroniser has really seen the pin low
    localparam logic OEN_IDLE = 1'b1;

    sys_st_t ms_q;        // system state
    sys_st_t ms_d;        // its next value
    logic    fifo_some;   // crossing fifo holds a word
    logic    stc_rise;    // storage clock rising edge seen
    logic    clr_active;  // synchronised clear is low
    logic    mir_load;    // mirror takes a buffered word

    // channels into and out of the two-entry buffer
    sipo_stream_if fifo_ch ();
    sipo_stream_if mir_ch ();

    // only the second flops, and stc_s3 after them, feed logic
    assign fifo_some  = (to_gray(ms_q.rbin) != ms_q.wg_s2);
    assign stc_rise   = ms_q.stc_s2 && !ms_q.stc_s3;
    assign clr_active = !ms_q.clr_s2;

    // fifo side of the buffer: offer the oldest snapshot
    // the entry is stable: it was written before its pointer moved
    assign fifo_ch.valid = fifo_some && !clr_active;
    assign fifo_ch.data  = lp_q.mem[ms_q.rbin[sipo_pkg::IDX_W-1:0]];

    // mirror stalls on a storage edge so the copy sees the old word;
    // during clear the buffer is drained and its words are dropped
    assign mir_ch.ready = clr_active || !stc_rise;
    assign mir_load     = mir_ch.valid && mir_ch.ready && !clr_active;

    // the buffer keeps words while the mirror stalls
    sipo_two_entry_buf u_buf (
        .i_mclk (i_mclk),
        .i_rstn (i_rstn),
        .up     (fifo_ch),
        .dn     (mir_ch)
    );

    // next system state
    always_comb begin
        ms_d = ms_q;
        // two-flop synchronisers for every controller pin and the write pointer
        ms_d.clr_s1 = i_shift_clear_n;
        ms_d.clr_s2 = ms_q.clr_s1;
        ms_d.stc_s1 = i_storage_clock;
        ms_d.stc_s2 = ms_q.stc_s1;
        ms_d.stc_s3 = ms_q.stc_s2;
        ms_d.oen_s1 = i_output_enable_n;
        ms_d.oen_s2 = ms_q.oen_s1;
        ms_d.wg_s1  = lp_q.wgray;
        ms_d.wg_s2  = ms_q.wg_s1;
        // reader advances when the buffer takes a word
        if (fifo_ch.valid && fifo_ch.ready) begin
            ms_d.rbin = ms_q.rbin + sipo_pkg::PTR_ONE;
        end
        // mirror follows the stage snapshots in order
        if (mir_load) begin
            ms_d.mirror = mir_ch.data;
        end
        // clear: stages are zero, pending snapshots are stale
        if (clr_active) begin
            ms_d.rbin   = to_bin(ms_q.wg_s2);
            ms_d.mirror = sipo_pkg::ZERO_WORD;
        end
        // storage copies on the rising edge only; the clear does
        // not touch it, and it takes the word held before the edge
        if (stc_rise) begin
            ms_d.store = ms_q.mirror;
        end
        // pins float while the enable pin is high
        ms_d.drive = !ms_q.oen_s2;
    end

    // system state register; pins start floating
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            ms_q        <= '0;
            ms_q.oen_s1 <= OEN_IDLE;
            ms_q.oen_s2 <= OEN_IDLE;
        end else begin
            ms_q <= ms_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // pins: values and enables from flip-flops

    // storage register drives the pins when enabled
    assign o_parallel_out = ms_q.store;
    assign o_parallel_oe  = ms_q.drive ? sipo_pkg::ONES_WORD
                                       : sipo_pkg::ZERO_WORD;

    ////////////////////////////////////////////////////////////////
    // checks on the link domain

    // stage 0 takes the serial pin on each rising edge
    property p_first_stage;
        @(posedge i_shift_clock) disable iff (!link_rst_n)
        1'b1 |=> sh_q.shreg[0] == $past(i_serial_in);
    endproperty
    a_first_stage: assert property (p_first_stage)
        else $error("stage 0 missed serial input");

    // other stages take their neighbour's old value
    property p_stage_move;
        @(posedge i_shift_clock) disable iff (!link_rst_n)
        1'b1 |=> sh_q.shreg[sipo_pkg::LAST:1]
                 == $past(sh_q.shreg[sipo_pkg::LAST-1:0]);
    endproperty
    a_stage_move: assert property (p_stage_move)
        else $error("stages did not shift by one");

    // cascade pin shows what stage seven held an edge before
    property p_cascade;
        @(posedge i_shift_clock) disable iff (!link_rst_n)
        1'b1 |=> o_cascade_out == $past(sh_q.shreg[sipo_pkg::LAST-1]);
    endproperty
    a_cascade: assert property (p_cascade)
        else $error("cascade output not last stage");

    // fifo write pointer only grows by one per edge
    property p_wptr_step;
        @(posedge i_shift_clock) disable iff (!i_rstn)
        1'b1 |=> lp_q.wbin == $past(lp_q.wbin) + sipo_pkg::PTR_ONE;
    endproperty
    a_wptr_step: assert property (p_wptr_step)
        else $error("snapshot pointer skipped");

    ////////////////////////////////////////////////////////////////
    // checks on the system domain

    // stages are zero whenever the clear pin is seen low
    property p_clear_now;
        @(posedge i_mclk) disable iff (!i_rstn)
        !i_shift_clear_n |-> sh_q.shreg == sipo_pkg::ZERO_WORD;
    endproperty
    a_clear_now: assert property (p_clear_now)
        else $error("clear did not zero the stages");

    // mirror is zero one cycle into a seen clear
    property p_clear_mirror;
        @(posedge i_mclk) disable iff (!i_rstn)
        clr_active |=> ms_q.mirror == sipo_pkg::ZERO_WORD;
    endproperty
    a_clear_mirror: assert property (p_clear_mirror)
        else $error("mirror kept data under clear");

    // storage edge copies the word held before it
    property p_store_copy;
        @(posedge i_mclk) disable iff (!i_rstn)
        stc_rise |=> o_parallel_out == $past(ms_q.mirror);
    endproperty
    a_store_copy: assert property (p_store_copy)
        else $error("storage did not copy stages");

    // without a storage edge the pins hold, clear or not
    property p_store_hold;
        @(posedge i_mclk) disable iff (!i_rstn)
        !stc_rise |=> $stable(o_parallel_out);
    endproperty
    a_store_hold: assert property (p_store_hold)
        else $error("storage changed without an edge");

    // mirror does not move in the cycle of a storage copy outside a clear
    property p_lag_one;
        @(posedge i_mclk) disable iff (!i_rstn)
        stc_rise && !clr_active |=> ms_q.mirror == $past(ms_q.mirror);
    endproperty
    a_lag_one: assert property (p_lag_one)
        else $error("mirror moved during storage copy");

    // enable pin high floats all eight pins three cycles on
    property p_float;
        @(posedge i_mclk) disable iff (!i_rstn)
        ms_q.oen_s2 |=> o_parallel_oe == sipo_pkg::ZERO_WORD;
    endproperty
    a_float: assert property (p_float)
        else $error("pins driven with enable high");

    // enable pin low drives all eight pins
    property p_drive;
        @(posedge i_mclk) disable iff (!i_rstn)
        !ms_q.oen_s2 |=> o_parallel_oe == sipo_pkg::ONES_WORD;
    endproperty
    a_drive: assert property (p_drive)
        else $error("pins floating with enable low");

    // cascade pin is low whenever the clear pin is seen low
    property p_cascade_clear;
        @(posedge i_mclk) disable iff (!i_rstn)
        !i_shift_clear_n |-> !o_cascade_out;
    endproperty
    a_cascade_clear: assert property (p_cascade_clear)
        else $error("cascade not low under clear");

    // the crossing fifo never holds more words than it has slots
    property p_fifo_room;
        @(posedge i_mclk) disable iff (!i_rstn)
        1'b1 |-> sipo_pkg::ptr_t'(to_bin(ms_q.wg_s2) - ms_q.rbin)
                 <= sipo_pkg::ptr_t'(sipo_pkg::DEPTH);
    endproperty
    a_fifo_room: assert property (p_fifo_room)
        else $error("crossing fifo overrun");

    // a storage edge under a settled clear stores zeros
    property p_clear_store;
        @(posedge i_mclk) disable iff (!i_rstn)
        stc_rise && clr_active && $past(clr_active) |=> o_parallel_out == sipo_pkg::ZERO_WORD;
    endproperty
    a_clear_store: assert property (p_clear_store)
        else $error("storage kept data under clear");

endmodule : serial_in_parallel_out_latch

/* hw/sipo_pkg.sv */
// constants and types shared by the shift/storage latch and its buffer
// assumes a two-clock design: a system clock and the link's shift clock
package sipo_pkg;
    // shift and storage register width
    localparam int WIDTH = 8;
    // index of the last (cascade) stage
    localparam int LAST = WIDTH - 1;
    // crossing fifo: four entries, gray pointers one bit wider
    localparam int DEPTH = 4;
    localparam int PTR_W = 3;
    localparam int IDX_W = PTR_W - 1;
    // two-entry buffer between crossing fifo and mirror
    localparam int BUF_DEPTH = 2;
    localparam int CNT_W = 2;
    // word and pointer types
    typedef logic [WIDTH-1:0] word_t;
    typedef logic [PTR_W-1:0] ptr_t;
    typedef logic [CNT_W-1:0] cnt_t;
    // reset and constant values
    localparam word_t ZERO_WORD = 8'h00;
    localparam word_t ONES_WORD = 8'hff;
    localparam ptr_t  PTR_ZERO  = 3'h0;
    localparam ptr_t  PTR_ONE   = 3'h1;
    localparam cnt_t  CNT_ZERO  = 2'h0;
    localparam cnt_t  CNT_ONE   = 2'h1;
    localparam cnt_t  CNT_FULL  = 2'h2;
    // least clear pulse seen by the system clock, in ns, and in cycles
    localparam int MCLK_NS      = 40;
    localparam int CLR_MIN_NS   = 160;
    localparam int CLR_MIN_CYC  = (CLR_MIN_NS + MCLK_NS - 1) / MCLK_NS;
endpackage : sipo_pkg

/* hw/sipo_stream_if.sv */
// one valid/ready word channel between the latch and its buffer
// assumes both ends run on the system clock
`timescale 1ns/100ps
interface sipo_stream_if;
    logic            valid; // word offered
    logic            ready; // word taken when both high
    sipo_pkg::word_t data;  // offered word
    // producer end
    modport src (output valid, output data, input ready);
    // consumer end
    modport snk (input valid, input data, output ready);
endinterface : sipo_stream_if

/* hw/sipo_two_entry_buf.sv */
// two-entry word buffer with valid and ready on both sides
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/100ps
module sipo_two_entry_buf (
    // clock and reset
    input  wire logic   i_mclk,
    input  wire logic   i_rstn,
    // filling side
    sipo_stream_if.snk  up,
    // draining side
    sipo_stream_if.src  dn
);
    // all state of the buffer
    typedef struct packed {
        sipo_pkg::word_t [sipo_pkg::BUF_DEPTH-1:0] mem; // entries
        sipo_pkg::cnt_t                            cnt; // fill level
        logic                                      wp;  // write slot
        logic                                      rp;  // read slot
    } buf_st_t;

    buf_st_t q;
    buf_st_t d;
    logic    push;
    logic    pop;

    ////////////////////////////////////////////////////////////////
    // honest flags: ready drops when both slots hold a word
    assign up.ready = (q.cnt != sipo_pkg::CNT_FULL);
    assign dn.valid = (q.cnt != sipo_pkg::CNT_ZERO);
    assign dn.data  = q.mem[q.rp];
    assign push     = up.valid && up.ready;
    assign pop      = dn.valid && dn.ready;

    // next state
    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wp] = up.data;
            d.wp        = ~q.wp;
        end
        if (pop) begin
            d.rp = ~q.rp;
        end
        // level moves only when one side acts alone
        if (push && !pop) begin
            d.cnt = q.cnt + sipo_pkg::CNT_ONE;
        end else if (pop && !push) begin
            d.cnt = q.cnt - sipo_pkg::CNT_ONE;
        end
    end

    // state register
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule : sipo_two_entry_buf
